/* design/dcf_fifo.sv */
// 16x5 fifo with strobe-edge load and unload, flags and ahb-lite port
//
// What this block does
// - rising write_strobe stores the input word unless full.
// - rising read_strobe moves to the next stored word unless empty.
// - full means sixteen more words written than read.
// - write strobe edges while full change nothing.
// - read strobe edges while empty change nothing.
// - full flag low at sixteen words, high otherwise.
// - nearly-full flag low at exactly fourteen words.
// - empty flag low at zero words, high otherwise.
// - nearly-empty flag low at exactly two words.
// - reset clears both pointers and drives empty low.
// - reset drives full, nearly-full and nearly-empty high.
// - reset zeroes the data outputs, a value nothing may rely on.
// - first write into an empty fifo shows its word, no read needed.
// - outputs show the oldest word without unloading it.
// - output enable low releases data pins, high drives them.
// - output enable never touches the flag outputs.
// - stored data comes out with its input polarity.
// - storage is sixteen words of five bits.
// - data output is meaningless while the count is zero.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module dcf_fifo
	import dcf_pkg::*;
(
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic                         hready,
	input  wire logic [31:0]                  hwdata,
	output logic      [31:0]                  hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	input  wire logic                         write_strobe,
	input  wire logic                         read_strobe,
	input  wire logic [dcf_pkg::DCF_WIDTH-1:0] d_in,
	input  wire logic                         output_enable,
	output logic      [dcf_pkg::DCF_WIDTH-1:0] q_out,
	output logic                              q_oe_n,
	output logic                              full_n,
	output logic                              nfull_n,
	output logic                              empty_n,
	output logic                              nempty_n
);
	import dcf_pkg::*;

	dcf_state_type s_q;
	dcf_state_type s_d;

	// register map on the ahb-lite port, one aligned word each:
	//   ctrl   bit 0 lets strobe edges through, bit 1 empties the
	//          store when written as one and always reads zero
	//   status count in the low five bits, the four flags above
	//   head   the word now shown on the data outputs
	// the port never stalls and always answers okay, so software
	// sees a register effect two cycles after its address phase

	// ---------------------------------------------------------------
	// combinational helpers
	// ---------------------------------------------------------------
	logic [DCF_CW-1:0] cnt_q;
	logic [DCF_CW-1:0] cnt_nx;
	logic              wr_edge;
	logic              rd_edge;
	logic              wr_go;
	logic              rd_go;
	logic              flush;
	logic              bus_wr;
	logic              addr_take;
	logic [31:0]       rd_mux;

	// occupancy is the pointer distance; one extra bit tells full
	// from empty without a separate counter
	assign cnt_q   = s_q.wr_ptr - s_q.rd_ptr;
	// a strobe counts only on a low-to-high step between two samples;
	// the previous-level bits come out of reset high, so a strobe
	// held high through reset cannot fake a load or an unload
	assign wr_edge = write_strobe & ~s_q.wr_prev;
	assign rd_edge = read_strobe & ~s_q.rd_prev;

	// edges are dropped outright at the limits
	// and while software has the strobes switched off
	assign wr_go = wr_edge & s_q.strobe_en & (cnt_q != DCF_CNT_FULL);
	assign rd_go = rd_edge & s_q.strobe_en & (cnt_q != DCF_CNT_EMPTY);

	// data phase of a bus write and the address phase taken now
	assign bus_wr    = s_q.ph_valid & s_q.ph_write;
	assign addr_take = hsel & hready & (htrans == DCF_HTRANS_NONSEQ)
		& (hsize == DCF_HSIZE_WORD);
	assign flush = bus_wr & (s_q.ph_addr == DCF_OFS_CTRL)
		& hwdata[DCF_CTRL_FLUSH];

	// read mux for the register port, unmapped words read zero
	// taken from the address phase and registered for the data phase
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr[7:0])
			DCF_OFS_CTRL: begin
				rd_mux[DCF_CTRL_EN] = s_q.strobe_en;
			end
			DCF_OFS_STATUS: begin
				rd_mux[DCF_CW-1:0]      = cnt_q;
				rd_mux[DCF_ST_FULL_N]   = s_q.full_n;
				rd_mux[DCF_ST_NFULL_N]  = s_q.nfull_n;
				rd_mux[DCF_ST_EMPTY_N]  = s_q.empty_n;
				rd_mux[DCF_ST_NEMPTY_N] = s_q.nempty_n;
			end
			DCF_OFS_HEAD: begin
				rd_mux[DCF_WIDTH-1:0] = s_q.q_data;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d         = s_q;
		s_d.wr_prev = write_strobe;
		s_d.rd_prev = read_strobe;

		// storing and advancing share one clock, so both may fire in
		// the same cycle when the fifo is between its limits
		if (wr_go) begin
			s_d.mem[s_q.wr_ptr[DCF_AW-1:0]] = d_in;
			s_d.wr_ptr = s_q.wr_ptr + 5'h01;
		end
		if (rd_go) begin
			s_d.rd_ptr = s_q.rd_ptr + 5'h01;
		end
		// a flush lines the write pointer up with the read pointer as
		// it leaves this cycle, so an unload in the same cycle cannot
		// leave the distance wrapped round to a bogus count
		if (flush) begin
			s_d.wr_ptr = s_d.rd_ptr;
		end

		// flags are registered from the next occupancy so they line up
		// with the pointers they describe
		cnt_nx     = s_d.wr_ptr - s_d.rd_ptr;
		s_d.full_n   = (cnt_nx != DCF_CNT_FULL);
		s_d.nfull_n  = (cnt_nx != DCF_CNT_NFULL);
		s_d.empty_n  = (cnt_nx != DCF_CNT_EMPTY);
		s_d.nempty_n = (cnt_nx != DCF_CNT_NEMPTY);

		// head word follows the read pointer, so a write into an empty
		// fifo shows up without any unload; stale when count is zero
		s_d.q_data = s_d.mem[s_d.rd_ptr[DCF_AW-1:0]];
		s_d.q_oen  = ~output_enable;

		// ahb-lite slave, zero wait states, always okay
		// the address phase is latched on every ready cycle; only a
		// valid word-sized nonseq one arms a data phase
		if (bus_wr && s_q.ph_addr == DCF_OFS_CTRL) begin
			s_d.strobe_en = hwdata[DCF_CTRL_EN];
		end
		if (hready) begin
			s_d.ph_valid = addr_take;
			s_d.ph_write = hwrite;
			s_d.ph_addr  = haddr[7:0];
			s_d.hrdata   = (addr_take & ~hwrite) ? rd_mux : 32'h0000_0000;
		end
		s_d.hreadyout = 1'b1;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// storage and data outputs come up as zero only to keep them known
	// nothing outside may rely on them while the store is empty
	// one register for the whole state keeps every output a flop except hresp, which is tied to okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q           <= '0;
			s_q.wr_prev   <= 1'b1;
			s_q.rd_prev   <= 1'b1;
			s_q.q_oen     <= 1'b1;
			s_q.full_n    <= 1'b1;
			s_q.nfull_n   <= 1'b1;
			s_q.nempty_n  <= 1'b1;
			s_q.empty_n   <= 1'b0;
			s_q.strobe_en <= DCF_CTRL_EN_RST;
			s_q.hreadyout <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all but hresp straight from the state register
	// ---------------------------------------------------------------
	assign q_out     = s_q.q_data;
	assign q_oe_n    = s_q.q_oen;
	assign full_n    = s_q.full_n;
	assign nfull_n   = s_q.nfull_n;
	assign empty_n   = s_q.empty_n;
	assign nempty_n  = s_q.nempty_n;
	assign hrdata    = s_q.hrdata;
	assign hreadyout = s_q.hreadyout;
	assign hresp     = 1'b0;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// the checks below read the registered state and the sampled strobe, enable and bus inputs, so every one
	// of them looks at values that have settled since the last edge;
	// in the flag checks occupancy is recomputed from the pointers, never taken
	// from the flags that it is meant to judge

	// ---------------------------------------------------------------
	// flag checks
	// ---------------------------------------------------------------

	property p_full_flag;
		full_n == (cnt_q != DCF_CNT_FULL);
	endproperty
	a_full_flag: assert property (p_full_flag)
		else $error("full flag disagrees with occupancy");

	property p_nfull_flag;
		(cnt_q == 5'h0e) |-> !nfull_n;
	endproperty
	a_nfull_flag: assert property (p_nfull_flag)
		else $error("nearly-full not low at fourteen words");

	property p_nfull_clear;
		(cnt_q != DCF_CNT_NFULL) |-> nfull_n;
	endproperty
	a_nfull_clear: assert property (p_nfull_clear)
		else $error("nearly-full low away from fourteen words");

	property p_empty_flag;
		empty_n == (cnt_q != 5'h00);
	endproperty
	a_empty_flag: assert property (p_empty_flag)
		else $error("empty flag disagrees with occupancy");

	property p_nempty_flag;
		nempty_n == (cnt_q != 5'h02);
	endproperty
	a_nempty_flag: assert property (p_nempty_flag)
		else $error("nearly-empty flag disagrees with occupancy");

	property p_full_by_write;
		(cnt_q == 5'h0f && wr_go && !rd_go && !flush) |=> !full_n;
	endproperty
	a_full_by_write: assert property (p_full_by_write)
		else $error("sixteenth load left full flag high");

	property p_empty_by_read;
		(cnt_q == 5'h01 && rd_go && !wr_go && !flush) |=> !empty_n;
	endproperty
	a_empty_by_read: assert property (p_empty_by_read)
		else $error("last unload left empty flag high");

	// a flush must land on zero even with an unload in flight
	property p_flush_empty;
		flush |=> !empty_n && cnt_q == DCF_CNT_EMPTY;
	endproperty
	a_flush_empty: assert property (p_flush_empty)
		else $error("flush left words behind");

	// flags move only with a load, an unload or a flush, never with
	// the output enable
	property p_flags_quiet;
		(!wr_go && !rd_go && !flush)
			|=> $stable({full_n, nfull_n, empty_n, nempty_n});
	endproperty
	a_flags_quiet: assert property (p_flags_quiet)
		else $error("flags moved with no load or unload");

	// ---------------------------------------------------------------
	// pointer and storage checks
	// ---------------------------------------------------------------
	property p_count_range;
		cnt_q <= DCF_CNT_FULL;
	endproperty
	a_count_range: assert property (p_count_range)
		else $error("occupancy beyond sixteen words");

	property p_wr_when_full;
		(wr_edge && !full_n && !flush) |=> $stable(s_q.wr_ptr)
			&& (full_n == $past(rd_go));
	endproperty
	a_wr_when_full: assert property (p_wr_when_full)
		else $error("write taken while full");

	property p_rd_when_empty;
		(rd_edge && !empty_n) |=> $stable(s_q.rd_ptr)
			&& ($past(wr_go) || $stable(q_out));
	endproperty
	a_rd_when_empty: assert property (p_rd_when_empty)
		else $error("read taken while empty");

	property p_rd_empty_flags;
		(rd_edge && !empty_n && !wr_go) |=> !empty_n && nfull_n;
	endproperty
	a_rd_empty_flags: assert property (p_rd_empty_flags)
		else $error("unload while empty moved the flags");

	property p_wr_full_mem;
		(wr_edge && !full_n) |=> $stable(s_q.mem);
	endproperty
	a_wr_full_mem: assert property (p_wr_full_mem)
		else $error("load while full changed the store");

	property p_rd_advance;
		rd_go |=> s_q.rd_ptr == $past(s_q.rd_ptr) + 5'h01;
	endproperty
	a_rd_advance: assert property (p_rd_advance)
		else $error("accepted unload did not advance");

	// a load and an unload on one edge leave the count alone
	property p_both;
		(wr_go && rd_go && !flush) |=> $stable(cnt_q);
	endproperty
	a_both: assert property (p_both)
		else $error("load with unload changed the count");

	// ---------------------------------------------------------------
	// data path checks
	// ---------------------------------------------------------------

	property p_wr_store;
		(wr_go && !flush) |=> (s_q.wr_ptr == $past(s_q.wr_ptr) + 5'h01)
			&& s_q.mem[$past(s_q.wr_ptr[3:0])] == $past(d_in);
	endproperty
	a_wr_store: assert property (p_wr_store)
		else $error("accepted write not stored");

	property p_first_word;
		(!empty_n && wr_go && !rd_go && !flush) |=> empty_n
			&& (q_out == $past(d_in));
	endproperty
	a_first_word: assert property (p_first_word)
		else $error("first word not shown on outputs");

	property p_oe;
		$past(hresetn) |-> q_oe_n == !$past(output_enable);
	endproperty
	a_oe: assert property (p_oe)
		else $error("output enable not followed");

	property p_head;
		empty_n |-> q_out == s_q.mem[s_q.rd_ptr[3:0]];
	endproperty
	a_head: assert property (p_head)
		else $error("outputs do not show oldest word");

	property p_head_hold;
		(empty_n && !rd_go) |=> $stable(q_out);
	endproperty
	a_head_hold: assert property (p_head_hold)
		else $error("head word moved without an unload");

	// main scenarios the bench must reach
	c_fill: cover property (!full_n);
	c_both: cover property (wr_go && rd_go);
	c_first: cover property (!empty_n ##1 empty_n);
	c_flush: cover property (flush && empty_n);
	c_full_load: cover property (wr_edge && !full_n);

endmodule : dcf_fifo

/* common/dcf_pkg.sv */
// constants, register map and state type of the 16x5 strobed fifo
package dcf_pkg;

	// ---------------------------------------------------------------
	// storage geometry
	// ---------------------------------------------------------------
	localparam int unsigned DCF_WIDTH      = 5;
	localparam int unsigned DCF_DEPTH      = 16;
	localparam int unsigned DCF_AW         = 4;
	localparam int unsigned DCF_CW         = 5;

	// occupancy figures that drive the flags
	localparam logic [4:0]  DCF_CNT_FULL   = 5'h10;
	localparam logic [4:0]  DCF_CNT_NFULL  = 5'h0e;
	localparam logic [4:0]  DCF_CNT_NEMPTY = 5'h02;
	localparam logic [4:0]  DCF_CNT_EMPTY  = 5'h00;

	// ---------------------------------------------------------------
	// register map, byte addresses on the ahb-lite port
	// ---------------------------------------------------------------
	localparam logic [7:0]  DCF_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  DCF_OFS_STATUS = 8'h04;
	localparam logic [7:0]  DCF_OFS_HEAD   = 8'h08;

	// ctrl field positions
	localparam int unsigned DCF_CTRL_EN    = 0;
	localparam int unsigned DCF_CTRL_FLUSH = 1;
	localparam logic        DCF_CTRL_EN_RST = 1'b1;

	// status field positions (count sits in the low bits)
	localparam int unsigned DCF_ST_FULL_N   = 8;
	localparam int unsigned DCF_ST_NFULL_N  = 9;
	localparam int unsigned DCF_ST_EMPTY_N  = 10;
	localparam int unsigned DCF_ST_NEMPTY_N = 11;

	// ahb-lite encodings
	localparam logic [1:0]  DCF_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  DCF_HSIZE_WORD    = 3'h2;

	// ---------------------------------------------------------------
	// whole state of the top module
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [DCF_DEPTH-1:0][DCF_WIDTH-1:0] mem;
		logic [DCF_CW-1:0]                   wr_ptr;
		logic [DCF_CW-1:0]                   rd_ptr;
		logic                                wr_prev;
		logic                                rd_prev;
		logic [DCF_WIDTH-1:0]                q_data;
		logic                                q_oen;
		logic                                full_n;
		logic                                nfull_n;
		logic                                empty_n;
		logic                                nempty_n;
		logic                                strobe_en;
		logic                                ph_valid;
		logic                                ph_write;
		logic [7:0]                          ph_addr;
		logic [31:0]                         hrdata;
		logic                                hreadyout;
	} dcf_state_type;

endpackage : dcf_pkg

/* test/dcf_partner.sv */
// producer and consumer logic that strobe the fifo
`timescale 1ns/1ns
module dcf_partner
	import dcf_pkg::*;
(
	output logic                           write_strobe,
	output logic                           read_strobe,
	output logic [dcf_pkg::DCF_WIDTH-1:0]  d_in,
	input  wire logic                      hclk
);
	// idle low, so the first rise after reset is a real edge
	initial begin
		write_strobe = 1'b0;
		read_strobe  = 1'b0;
		d_in         = '0;
	end

	// one low and one high cycle per edge; one part only, never
	// chained behind another for depth
	task automatic pulse(input logic ld, input logic ul,
		input logic [DCF_WIDTH-1:0] w);
		@(posedge hclk);
		write_strobe <= 1'b0;
		read_strobe  <= 1'b0;
		d_in         <= w;
		@(posedge hclk);
		write_strobe <= ld;
		read_strobe  <= ul;
		@(posedge hclk);
		write_strobe <= 1'b0;
		read_strobe  <= 1'b0;
		// hold is over: show a changed word, never the stale one
		d_in         <= ~w;
		#1;
	endtask : pulse
endmodule : dcf_partner

/* test/dcf_fifo_tb_top.sv */
// self-checking bench of the strobed fifo and its register port
`timescale 1ns/1ns
module dcf_fifo_tb_top;
	import dcf_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = '0;
	logic [31:0] hwdata = '0;
	logic        output_enable = 1'b1;
	logic [31:0] hrdata, rd;
	logic        hreadyout, hresp, write_strobe, read_strobe, q_oe_n;
	logic        full_n, nfull_n, empty_n, nempty_n;
	logic [4:0]  d_in, q_out;
	// released pins float, as on a real bus
	wire  [4:0]  q_pin = q_oe_n ? 5'bzzzzz : q_out;
	int          n_errors = 0;
	int          comparisons = 0;

	always #25 hclk = ~hclk;

	dcf_fifo i_dcf_fifo (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.write_strobe(write_strobe), .read_strobe(read_strobe),
		.d_in(d_in), .output_enable(output_enable), .q_out(q_out),
		.q_oe_n(q_oe_n), .full_n(full_n), .nfull_n(nfull_n),
		.empty_n(empty_n), .nempty_n(nempty_n));

	dcf_partner i_dcf_partner (.write_strobe(write_strobe),
		.read_strobe(read_strobe), .d_in(d_in), .hclk(hclk));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// single word transfer; waits on hready, no fixed latency assumed
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge hclk);
		htrans <= DCF_HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= w;
		hsize  <= DCF_HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		#1;
	endtask : ahb

	// flag pins and status word both reckoned from the count alone
	task automatic chk_state(input int c);
		chk("flags", {28'h0, c != 16, c != 14, c != 0, c != 2},
			{28'h0, full_n, nfull_n, empty_n, nempty_n});
		ahb(1'b0, DCF_OFS_STATUS, 32'h0);
		chk("status", {20'h0, c != 2, c != 0, c != 14, c != 16, 3'h0,
			5'(c)}, rd);
	endtask : chk_state

	// pins and the head register must agree on the oldest word
	task automatic chk_q(input logic [4:0] e);
		chk("q_pin", {27'h0, e}, {27'h0, q_pin});
		ahb(1'b0, DCF_OFS_HEAD, 32'h0);
		chk("head", {27'h0, e}, rd);
	endtask : chk_q

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		chk_state(0);
		ahb(1'b0, DCF_OFS_CTRL, 32'h0);
		chk("ctrl", 32'h1, rd);
		ahb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : t_reset

	task automatic t_first();
		i_dcf_partner.pulse(1'b1, 1'b0, 5'h15);
		chk_q(5'h15);
		i_dcf_partner.pulse(1'b1, 1'b0, 5'h0a);
		chk_q(5'h15);
		chk_state(2);
		i_dcf_partner.pulse(1'b0, 1'b1, 5'h00);
		chk_q(5'h0a);
		i_dcf_partner.pulse(1'b0, 1'b1, 5'h00);
		chk_state(0);
		i_dcf_partner.pulse(1'b0, 1'b1, 5'h00);
		chk_state(0);
	endtask : t_first

	// seventeen loads: the last one meets a full store
	task automatic t_fill();
		for (int i = 0; i < 17; i++) begin
			i_dcf_partner.pulse(1'b1, 1'b0, 5'(i + 8));
			if (i == 13) chk_state(14);
		end
		chk_state(16);
		for (int i = 0; i < 16; i++) begin
			chk_q(5'(i + 8));
			i_dcf_partner.pulse(1'b0, 1'b1, 5'h00);
		end
		chk_state(0);
	endtask : t_fill

	task automatic t_oe();
		i_dcf_partner.pulse(1'b1, 1'b0, 5'h07);
		@(posedge hclk);
		output_enable <= 1'b0;
		repeat (2) @(posedge hclk);
		#1;
		chk("q_pin", {27'h0, 5'bzzzzz}, {27'h0, q_pin});
		chk_state(1);
		output_enable <= 1'b1;
		repeat (2) @(posedge hclk);
		#1;
		chk_q(5'h07);
	endtask : t_oe

	// strobe gating and flush, then load and unload on one edge
	task automatic t_ctrl();
		ahb(1'b1, DCF_OFS_CTRL, 32'h0);
		i_dcf_partner.pulse(1'b1, 1'b0, 5'h11);
		chk_state(1);
		ahb(1'b1, DCF_OFS_CTRL, 32'h3);
		chk_state(0);
		i_dcf_partner.pulse(1'b1, 1'b0, 5'h01);
		i_dcf_partner.pulse(1'b1, 1'b1, 5'h02);
		chk_state(1);
		chk_q(5'h02);
	endtask : t_ctrl

	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	// main sequence after twenty reset cycles
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		t_reset();
		t_first();
		t_fill();
		t_oe();
		t_ctrl();
		end_of_test();
	end

	// whole run needs well under a thousand cycles
	initial begin
		#1000000;
		n_errors++;
		end_of_test();
	end
endmodule : dcf_fifo_tb_top
